// ---- inc/wake_fail_diag_params.svh ----
// field positions, reset value, count limits and timing counts of the diagnosis status word
`ifndef WAKE_FAIL_DIAG_PARAMS_SVH
`define WAKE_FAIL_DIAG_PARAMS_SVH

`define CLK_PERIOD_NS 20
`define WORD_RESET 16'h0000
`define ORIGIN_MSB 13
`define ORIGIN_LSB 12
`define UV_FLAG_BIT 11
`define THERM_MSB 10
`define THERM_LSB 8
`define FAIL_MSB 7
`define FAIL_LSB 4
`define TRIG_FORCE_BIT 3
`define THERM_FORCE_BIT 2
`define PROG_MSB 1
`define PROG_LSB 0
`define THERM_LIMIT 7
`define FAIL_LIMIT 7
`define UV_TIME_NS 2000
`define UV_CYCLES ((`UV_TIME_NS / `CLK_PERIOD_NS) + 1)
`define QUIET_TIME_S 60
`define QUIET_CYCLES ((64'd`QUIET_TIME_S * 64'd1000000000) / 64'd`CLK_PERIOD_NS)

`endif

// ---- inc/wake_fail_diag_pkg.sv ----
// types shared by the diagnosis status block
package wake_fail_diag_pkg;

	typedef enum logic [1:0] {
		ST_ACTIVE,
		ST_REG_STANDBY,
		ST_BAT_STANDBY,
		ST_FLASH
	} dev_state_e;

	typedef struct packed {
		logic below_2v;       // regulator output under 2 V, level
		logic severe_thermal; // severe_thermal_shutdown restarted the regulator, pulse
		logic trig_ok;        // correct watchdog trigger, pulse
		logic trig_fail;      // failing watchdog trigger, pulse
		logic startup_short;  // short on regulator output during startup, pulse
		logic wake;           // wake-up happened, pulse
	} diag_event_s;

endpackage

// ---- hdl/hold_timer.sv ----
// counts cycles while a condition holds and flags when the limit is reached
`timescale 1ns/1ps
module hold_timer #(
	parameter int WIDTH = 32,
	parameter logic [WIDTH-1:0] LIMIT = 100
) (
	input wire logic i_core_clk,   // core clock
	input wire logic i_reset,      // async reset, high
	input wire logic i_run,        // condition holds
	output logic o_done            // limit reached, level while i_run stays
);
	logic [WIDTH-1:0] cnt_q;
	logic [WIDTH-1:0] cnt_d;
	wire at_limit = (cnt_q >= LIMIT);

	// restarts the moment the condition drops; saturates so it never wraps
	assign cnt_d = !i_run ? '0 : (at_limit ? cnt_q : cnt_q + 1'b1);
	assign o_done = i_run && at_limit;

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule // hold_timer

// ---- hdl/wake_fail_diag_status.sv ----
// diagnosis status word: wake origin, regulator fail, restart and trigger counts, forced standby
`timescale 1ns/1ps
`include "wake_fail_diag_params.svh"
module wake_fail_diag_status
	import wake_fail_diag_pkg::*;
#(
	parameter logic [31:0] QUIET_CYCLES = 32'(`QUIET_CYCLES),
	parameter int THERM_LIMIT = `THERM_LIMIT,
	parameter int FAIL_LIMIT = `FAIL_LIMIT,
	parameter int WD_WIDTH = 16
) (
	input wire logic i_core_clk,                 // 50 MHz core clock
	input wire logic i_reset,                    // async reset, high
	input wire diag_event_s i_evt,               // event inputs from the monitors
	input wire dev_state_e i_wake_from,          // state left at a wake-up
	input wire dev_state_e i_present_state,      // present operating state
	input wire logic [WD_WIDTH-1:0] i_wd_elapsed, // watchdog counter value
	input wire logic [WD_WIDTH-1:0] i_wd_period,  // selected watchdog period
	input wire logic i_read_clear,               // read-and-clear access, pulse
	output logic [15:0] o_status_word,           // status word as read
	output logic o_force_standby                 // pulse: enter battery-only standby
);
	localparam logic [2:0] THERM_MAX = 3'(THERM_LIMIT);
	localparam logic [3:0] FAIL_MAX = 4'(FAIL_LIMIT);
	localparam logic [3:0] FAIL_SAT = 4'hF;

	// slots of the read-and-clear flags in the flag vector
	localparam int N_FLAGS = 3;
	localparam int FLAG_UV = 0;
	localparam int FLAG_TRIG = 1;
	localparam int FLAG_THERM = 2;

	// wake origin field
	dev_state_e origin_q;
	dev_state_e origin_d;
	logic origin_refresh;

	// thermal restart count and its decode
	logic [2:0] therm_q;
	logic [2:0] therm_d;
	logic therm_at_max;
	logic therm_hit;
	logic therm_reach;

	// failed trigger count and its decode
	logic [3:0] fail_q;
	logic [3:0] fail_d;
	logic fail_bad;
	logic fail_at_sat;
	logic fail_reach;

	// read-and-clear flags and the events that set them
	logic [N_FLAGS-1:0] flag_q;
	logic [N_FLAGS-1:0] flag_d;
	logic [N_FLAGS-1:0] flag_set;
	logic therm_cause;

	// watchdog window progress, live
	logic [WD_WIDTH+1:0] el3;
	logic [WD_WIDTH+1:0] per1;
	logic [WD_WIDTH+1:0] per2;
	logic in_last_third;
	logic in_mid_third;
	logic [1:0] prog_q;
	logic [1:0] prog_d;

	// assembled word and standby request
	logic [15:0] word_d;
	logic force_d;

	// timer handshakes
	logic uv_long;
	logic quiet_run;
	logic quiet_done;

	// undervoltage must persist past 2 us; glitches shorter are filtered
	hold_timer #(
		.WIDTH(8),
		.LIMIT(8'(`UV_CYCLES))
	) u_uv_timer (
		.i_core_clk(i_core_clk),
		.i_reset(i_reset),
		.i_run(i_evt.below_2v),
		.o_done(uv_long)
	);

	// quiet minute runs only while the count is nonzero; a new severe thermal event restarts it
	assign quiet_run = (therm_q != 3'h0) && !i_evt.severe_thermal;

	// 32 bits cover a minute at this clock; a much faster clock needs a wider timer
	hold_timer #(
		.WIDTH(32),
		.LIMIT(QUIET_CYCLES)
	) u_quiet_timer (
		.i_core_clk(i_core_clk),
		.i_reset(i_reset),
		.i_run(quiet_run),
		.o_done(quiet_done)
	);

	// wake capture beats the refresh so a wake during the read is not lost
	assign origin_refresh = i_read_clear && !i_evt.wake;
	assign origin_d = dev_state_e'(i_evt.wake ? i_wake_from :
		(origin_refresh ? i_present_state : origin_q));

	// thermal count saturates at its limit and clears after a quiet minute
	assign therm_at_max = (therm_q == THERM_MAX);
	assign therm_hit = i_evt.severe_thermal && !therm_at_max;
	assign therm_reach = therm_hit && (therm_q == THERM_MAX - 3'h1);
	assign therm_d = therm_hit ? therm_q + 3'h1 :
		(quiet_done ? 3'h0 : therm_q);

	// failed triggers count up, saturate at 15; a good trigger wins and clears
	assign fail_bad = i_evt.trig_fail && !i_evt.trig_ok;
	assign fail_at_sat = (fail_q == FAIL_SAT);
	assign fail_reach = fail_bad && (fail_q == FAIL_MAX - 4'h1);
	assign fail_d = i_evt.trig_ok ? 4'h0 :
		((fail_bad && !fail_at_sat) ? fail_q + 4'h1 : fail_q);

	// a short at startup forces standby at once, without any count
	assign therm_cause = therm_reach || i_evt.startup_short;
	assign force_d = fail_reach || therm_cause;

	// what sets each read-and-clear flag
	assign flag_set[FLAG_UV] = uv_long;
	assign flag_set[FLAG_TRIG] = fail_reach;
	assign flag_set[FLAG_THERM] = therm_cause;

	// one latch per flag: set wins over clear, so an event inside the read is kept
	for (genvar f = 0; f < N_FLAGS; f++) begin : g_flag
		assign flag_d[f] = flag_set[f] || (flag_q[f] && !i_read_clear);
	end

	// window thirds compared by cross multiplication, no divider needed; code 10 unused
	assign el3 = (WD_WIDTH+2)'(i_wd_elapsed) * (WD_WIDTH+2)'(3);
	assign per1 = (WD_WIDTH+2)'(i_wd_period);
	assign per2 = (WD_WIDTH+2)'(i_wd_period) << 1;
	assign in_last_third = (el3 >= per2);
	assign in_mid_third = (el3 >= per1);
	assign prog_d = in_last_third ? 2'h3 : (in_mid_third ? 2'h1 : 2'h0);

	// word from flop values only, so a clear in cycle n leaves cycle n's word intact
	// 15:14 read as zero, those bits are kept by logic outside this block
	// 13:12 state the device woke from
	// 11 regulator under 2 V for too long
	// 10:8 thermal restarts, saturating at seven
	// 7:4 failed triggers, saturating at fifteen
	// 3 standby forced by trigger errors
	// 2 standby forced by thermal restarts or a startup short
	// 1:0 window progress, live
	always_comb begin
		word_d = `WORD_RESET;
		word_d[`ORIGIN_MSB:`ORIGIN_LSB] = origin_q;
		word_d[`UV_FLAG_BIT] = flag_q[FLAG_UV];
		word_d[`THERM_MSB:`THERM_LSB] = therm_q;
		word_d[`FAIL_MSB:`FAIL_LSB] = fail_q;
		word_d[`TRIG_FORCE_BIT] = flag_q[FLAG_TRIG];
		word_d[`THERM_FORCE_BIT] = flag_q[FLAG_THERM];
		word_d[`PROG_MSB:`PROG_LSB] = prog_q;
	end

	// wake origin register
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			origin_q <= ST_ACTIVE;
		end else begin
			origin_q <= origin_d;
		end
	end

	// count registers; a read-and-clear leaves both counts alone
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			therm_q <= 3'h0;
			fail_q <= 4'h0;
		end else begin
			therm_q <= therm_d;
			fail_q <= fail_d;
		end
	end

	// read-and-clear flag register
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			flag_q <= '0;
		end else begin
			flag_q <= flag_d;
		end
	end

	// progress register; one more cycle of lag, traded for a clean flop boundary
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			prog_q <= 2'h0;
		end else begin
			prog_q <= prog_d;
		end
	end

	// status word output flop
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			o_status_word <= `WORD_RESET;
		end else begin
			o_status_word <= word_d;
		end
	end

	// standby request output flop, one cycle long; causes in the same cycle share one pulse
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			o_force_standby <= 1'b0;
		end else begin
			o_force_standby <= force_d;
		end
	end
endmodule // wake_fail_diag_status

// ---- dv/wake_fail_diag_status_chk.sv ----
// checker for the diagnosis status word
`timescale 1ns/1ps
module wake_fail_diag_status_chk
	import wake_fail_diag_pkg::*;
(
	input wire logic i_core_clk, // clock
	input wire logic i_reset, // reset
	input wire diag_event_s i_evt, // events
	input wire dev_state_e i_wake_from, // wake state
	input wire dev_state_e i_present_state, // present state
	input wire logic i_read_clear, // read-clear
	input wire logic [15:0] o_status_word, // word
	input wire logic o_force_standby // standby pulse
);
	// one domain, so clock and reset are given once
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	// the word lags an input by two samples
	origin_load_a: assert property (i_evt.wake |-> ##2 o_status_word[13:12] == $past(i_wake_from, 2))
		else $error("origin load");
	origin_refresh_a: assert property (i_read_clear && !i_evt.wake |-> ##2
		o_status_word[13:12] == $past(i_present_state, 2)) else $error("origin refresh");
	uv_set_a: assert property ($rose(o_status_word[11]) |-> $past(i_evt.below_2v, 2)) else $error("uv set");
	uv_clear_a: assert property (i_read_clear && !i_evt.below_2v |-> ##2 !o_status_word[11])
		else $error("uv clear");
	err_hold_a: assert property (o_status_word[3] && !$past(i_read_clear) |=> o_status_word[3])
		else $error("flag hold");
	force_cause_a: assert property (o_force_standby |->
		$past(i_evt.severe_thermal || i_evt.trig_fail || i_evt.startup_short)) else $error("force cause");
	short_force_a: assert property (i_evt.startup_short |=> o_force_standby ##1 o_status_word[2])
		else $error("short force");
	fail_stable_a: assert property (!$past(i_evt.trig_ok, 2) && !$past(i_evt.trig_fail, 2) |->
		$stable(o_status_word[7:4])) else $error("fail count");
	cover property (o_force_standby);
	cover property (i_read_clear && o_status_word[3]);
	cover property (o_status_word[10:8] == 3'h7);
endmodule // wake_fail_diag_status_chk

bind wake_fail_diag_status wake_fail_diag_status_chk wake_fail_diag_status_chk_inst (.*);

// ---- dv/wake_fail_diag_status_bench.sv ----
// bench for the diagnosis status word
`timescale 1ns/1ps
`define CHK(a,b) begin compares++; if ((a)!==(b)) begin failures++; $display("[FAIL] %0t %h %h",$time,a,b); end end
module wake_fail_diag_status_bench
	import wake_fail_diag_pkg::*;
;
	logic clk = 0, rst = 1, rd = 0, fs;
	diag_event_s ev = '0;
	dev_state_e wf = ST_ACTIVE, ps = ST_ACTIVE;
	logic [15:0] el = '0, w;
	int failures = 0, compares = 0, nf = 0;
	// quiet span cut to 50 cycles to keep the run short
	wake_fail_diag_status #(.QUIET_CYCLES(32'h32)) wake_fail_diag_status_inst (.i_core_clk(clk), .i_reset(rst),
		.i_evt(ev), .i_wake_from(wf), .i_present_state(ps), .i_wd_elapsed(el), .i_wd_period(16'h001E),
		.i_read_clear(rd), .o_status_word(w), .o_force_standby(fs));
	// clock and standby pulse count
	initial forever #10 clk = ~clk;
	always @(posedge clk) nf += fs;
	// events change at falling edges, then let the word settle
	task automatic go(input logic [5:0] e, input int n);
		@(negedge clk) ev = diag_event_s'(e);
		repeat (n) @(negedge clk);
		ev = '0;
		repeat (3) @(negedge clk);
	endtask
	task automatic rc(input logic [15:0] old);
		@(negedge clk) rd = 1;
		@(negedge clk) rd = 0;
		`CHK(w, old)
		repeat (2) @(negedge clk);
	endtask
	task automatic t_uv();
		go(6'h20, 101);
		`CHK(w, 16'h0000)
		go(6'h20, 102);
		rc(16'h0800);
		`CHK(w, 16'h0000)
		$display("uv test done");
	endtask
	task automatic t_cnt();
		repeat (7) go(6'h10, 1);
		`CHK({w, nf}, {16'h0704, 32'd1})
		repeat (40) @(negedge clk);
		`CHK(w, 16'h0704)
		repeat (20) @(negedge clk);
		`CHK(w, 16'h0004)
		repeat (7) go(6'h04, 1);
		`CHK(nf, 2)
		rc(16'h007C);
		`CHK(w, 16'h0070)
		go(6'h08, 1);
		`CHK(w, 16'h0000)
		go(6'h02, 1);
		`CHK({w, nf}, {16'h0004, 32'd3})
		rc(16'h0004);
		`CHK(w, 16'h0000)
		$display("count test done");
	endtask
	task automatic t_org();
		for (int i = 0; i < 4; i++) begin
			wf = dev_state_e'(i);
			go(6'h01, 1);
			`CHK(w[13:12], 2'(i))
		end
		ps = ST_REG_STANDBY;
		rc(16'h3000);
		`CHK(w, 16'h1000)
		$display("origin test done");
	endtask
	task automatic t_prog();
		for (int i = 0; i < 3; i++) begin
			el = 16'(i * 10);
			repeat (3) @(negedge clk);
			`CHK(w[1:0], 2'(i == 2 ? 3 : i))
		end
		$display("window test done");
	endtask
	task automatic end_sim();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// main sequence after 8 reset cycles
	initial begin
		repeat (8) @(negedge clk);
		rst = 0;
		t_uv();
		t_cnt();
		t_org();
		t_prog();
		end_sim();
	end
	// run needs about 400 cycles; cut a hang well after
	initial begin
		#50000;
		failures++;
		end_sim();
	end
endmodule // wake_fail_diag_status_bench
